// [hw/attr_pkg.sv]
// Purpose: Shared constants for the attribute border, plane, pan and page block.
// Assumes: Byte-wide indexed I/O link between host end and device end.
// Notes: Avalon offsets below are byte addresses of 32-bit words.
package attr_pkg;
  // ----------------------------------------------------------------
  // Indexed I/O ports
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_ATTR_WR = 16'h03C0;
  localparam logic [15:0] PORT_ATTR_RD = 16'h03C1;
  localparam logic [15:0] PORT_STAT_MONO = 16'h03BA;
  localparam logic [15:0] PORT_STAT_COLOR = 16'h03DA;
  // ----------------------------------------------------------------
  // Data register indices and layout
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_BORDER_COLOR = 5'h11;
  localparam logic [4:0] IDX_PLANE_ENABLE = 5'h12;
  localparam logic [4:0] IDX_FINE_SHIFT = 5'h13;
  localparam logic [4:0] IDX_COLOR_PAGE = 5'h14;
  localparam int ADDR_PAL_SRC_BIT = 5;
  localparam int MODE_P54_SEL_BIT = 7;
  localparam int MODE_PAN_COMPAT_BIT = 5;
  localparam logic [7:0] RST_REG = 8'h00;
  // ----------------------------------------------------------------
  // Panning
  // ----------------------------------------------------------------
  localparam int PAN_TAPS = 9;
  localparam logic [3:0] PAN_MAX_9DOT = 4'h8;
  localparam logic [3:0] PAN_MAX_256 = 4'h6;
  localparam logic [3:0] PAN_MAX_OTHER = 4'h7;
  // ----------------------------------------------------------------
  // Host controller registers on Avalon-MM
  // ----------------------------------------------------------------
  localparam logic [3:0] AVS_OFF_CMD = 4'h0;
  localparam logic [3:0] AVS_OFF_STATUS = 4'h4;
  localparam int CMD_INDEX_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int STAT_BUSY_BIT = 8;
endpackage

// [hw/attr_link_if.sv]
// Purpose: Indexed I/O link between the host end and the attribute device end.
// Assumes: Both ends share i_clk_sys; all signals are driven from flip-flops.
// Notes: A read answers with io_rvalid high for one cycle.
`timescale 1ns/1ps
interface attr_link_if;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_rvalid;
  modport host (output io_addr, output io_wr, output io_rd, output io_wdata,
                input io_rdata, input io_rvalid);
  modport dev (input io_addr, input io_wr, input io_rd, input io_wdata,
               output io_rdata, output io_rvalid);
endinterface

// [hw/attr_device.sv]
// Purpose: Border colour, plane enable, fine pan and colour page registers
//          with the pixel colour path they steer.
// Assumes: One pixel per enabled clock; palette lookup is done outside.
// Notes: Pixel output lags the pixel inputs by ten enabled clocks at no pan.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Index 11 selects border colour register
// - Border band shows border colour value
// - No border in narrow modes except 256
// - Index 12 selects plane enable register
// - Bits 5:4 route colour pair to status
// - Bits 3:0 gate colour planes into path
// - Index 13 selects fine pan register
// - Pan bits 3:0 shift pixels left
// - Nine-dot modes: 0-7 give 1-8, 8 none
// - 256 mode: even values 0-6 shift by half
// - Other modes shift n pixels, max seven
// - Index 14 selects colour page register
// - Page bits 3:2 drive colour bits 7:6
// - 256 mode passes attribute byte straight
// - Page bits 1:0 can replace bits 5:4
// - Reserved bits written zero, read zero
// - Write latch toggles, status read clears it
// - Mode bit 7 picks page bits for 5:4
// - Line compare forces zero pan until vsync
// - Address bits 4:0 index, bit 5 source
module attr_device
  import attr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  attr_link_if.dev link,
  input wire logic [7:0] i_mode_ctl,
  input wire logic i_mode_9dot,
  input wire logic i_mode_256,
  input wire logic i_mode_narrow,
  input wire logic i_active,
  input wire logic i_border_band,
  input wire logic i_line_compare,
  input wire logic i_vsync,
  input wire logic [5:0] i_palette,
  input wire logic [7:0] i_attr256,
  input wire logic [3:0] i_plane_data,
  output logic [3:0] o_plane_enabled,
  output logic [7:0] o_dac_color,
  output logic [1:0] o_status_mux,
  output logic [3:0] o_pan_pixels,
  output logic [4:0] o_attr_index,
  output logic o_palette_src
);

  logic data_phase_ff;
  logic [5:0] addr_ff;
  logic [7:0] border_color_ff;
  logic [5:0] plane_enable_ff;
  logic [3:0] fine_shift_ff;
  logic [3:0] color_page_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic pan_hold_ff;
  logic [7:0] line_ff [PAN_TAPS];
  logic [7:0] nxt_color;
  logic [3:0] nxt_pan;
  logic border_on;
  logic [7:0] nxt_dac;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [4:0] idx, input logic [7:0] bc,
                                          input logic [5:0] pe, input logic [3:0] fs,
                                          input logic [3:0] cp);
    unique case (idx)
      IDX_BORDER_COLOR: reg_read = bc;
      IDX_PLANE_ENABLE: reg_read = {2'h0, pe};
      IDX_FINE_SHIFT: reg_read = {4'h0, fs};
      IDX_COLOR_PAGE: reg_read = {4'h0, cp};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Number of pixels the image moves left for a programmed pan value.
  function automatic logic [3:0] pan_pixels(input logic [3:0] val, input logic nine,
                                            input logic wide);
    if (nine) begin
      pan_pixels = (val < PAN_MAX_9DOT) ? val + 4'h1 : 4'h0;
    end else if (wide) begin
      // Odd values are undefined; 1 to 5 round down to the even below, 7 gives none.
      pan_pixels = (val <= PAN_MAX_256) ? {1'b0, val[3:1]} : 4'h0;
    end else begin
      pan_pixels = (val <= PAN_MAX_OTHER) ? val : 4'h0;
    end
  endfunction

  function automatic logic [1:0] status_sel(input logic [1:0] sel, input logic [7:0] c);
    unique case (sel)
      2'b00: status_sel = {c[2], c[0]};
      2'b01: status_sel = {c[5], c[4]};
      2'b10: status_sel = {c[3], c[1]};
      2'b11: status_sel = {c[7], c[6]};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      data_phase_ff <= 1'b0;
    end else if (i_ce) begin
      if (link.io_rd && (link.io_addr == PORT_STAT_MONO || link.io_addr == PORT_STAT_COLOR)) begin
        data_phase_ff <= 1'b0;
      end else if (link.io_wr && link.io_addr == PORT_ATTR_WR) begin
        data_phase_ff <= !data_phase_ff;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      addr_ff <= 6'h00;
    end else if (i_ce && link.io_wr && link.io_addr == PORT_ATTR_WR && !data_phase_ff) begin
      addr_ff <= link.io_wdata[5:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      border_color_ff <= RST_REG;
      plane_enable_ff <= RST_REG[5:0];
      fine_shift_ff <= RST_REG[3:0];
      color_page_ff <= RST_REG[3:0];
    end else if (i_ce && link.io_wr && link.io_addr == PORT_ATTR_WR && data_phase_ff) begin
      unique case (addr_ff[4:0])
        IDX_BORDER_COLOR: border_color_ff <= link.io_wdata;
        IDX_PLANE_ENABLE: plane_enable_ff <= link.io_wdata[5:0];
        IDX_FINE_SHIFT: fine_shift_ff <= link.io_wdata[3:0];
        IDX_COLOR_PAGE: color_page_ff <= link.io_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Reads of the data port leave the write latch alone.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else if (i_ce) begin
      rvalid_ff <= link.io_rd;
      // Read data only move on a read, so they stand until the next one.
      if (link.io_rd && link.io_addr == PORT_ATTR_RD) begin
        rdata_ff <= reg_read(addr_ff[4:0], border_color_ff, plane_enable_ff,
                             fine_shift_ff, color_page_ff);
      end else if (link.io_rd && link.io_addr == PORT_ATTR_WR) begin
        rdata_ff <= {2'h0, addr_ff};
      end else if (link.io_rd) begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign link.io_rdata = rdata_ff;
  assign link.io_rvalid = rvalid_ff;

  // ----------------------------------------------------------------
  // Panning control
  // ----------------------------------------------------------------
  // Set wins over the vsync clear so a compare on the vsync cycle holds.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pan_hold_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_line_compare && i_mode_ctl[MODE_PAN_COMPAT_BIT]) begin
        pan_hold_ff <= 1'b1;
      end else if (i_vsync) begin
        pan_hold_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_pan = pan_hold_ff ? 4'h0 : pan_pixels(fine_shift_ff, i_mode_9dot, i_mode_256);
  end

  // ----------------------------------------------------------------
  // Colour path
  // ----------------------------------------------------------------
  always_comb begin
    if (i_mode_256) begin
      nxt_color = i_attr256;
    end else begin
      nxt_color[7:6] = color_page_ff[3:2];
      nxt_color[5:4] = i_mode_ctl[MODE_P54_SEL_BIT] ? color_page_ff[1:0]
                                                    : i_palette[5:4];
      nxt_color[3:0] = i_palette[3:0];
    end
  end

  // The pixel stream runs through a fixed delay; panning picks an earlier tap,
  // so later pixels appear sooner and the image moves left.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      for (int k = 0; k < PAN_TAPS; k++) begin
        line_ff[k] <= 8'h00;
      end
    end else if (i_ce) begin
      line_ff[0] <= nxt_color;
      for (int k = 1; k < PAN_TAPS; k++) begin
        line_ff[k] <= line_ff[k-1];
      end
    end
  end

  always_comb begin
    border_on = i_border_band && (!i_mode_narrow || i_mode_256);
    if (i_active) begin
      nxt_dac = line_ff[PAN_TAPS - 1 - int'(nxt_pan)];
    end else if (border_on) begin
      nxt_dac = border_color_ff;
    end else begin
      nxt_dac = 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_dac_color <= 8'h00;
      o_plane_enabled <= 4'h0;
      o_status_mux <= 2'h0;
      o_pan_pixels <= 4'h0;
      o_attr_index <= 5'h00;
      o_palette_src <= 1'b0;
    end else if (i_ce) begin
      o_dac_color <= nxt_dac;
      o_plane_enabled <= i_plane_data & plane_enable_ff[3:0];
      o_status_mux <= status_sel(plane_enable_ff[5:4], nxt_dac);
      o_pan_pixels <= nxt_pan;
      o_attr_index <= addr_ff[4:0];
      o_palette_src <= addr_ff[ADDR_PAL_SRC_BIT];
    end
  end

endmodule // attr_device

// [hw/attr_host.sv]
// Purpose: Host end: turns Avalon-MM commands into indexed I/O sequences.
// Assumes: Device end answers a read with io_rvalid one enabled clock later.
// Notes: Every command first clears the device write latch by a status read.
`timescale 1ns/1ps
module attr_host
  import attr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  attr_link_if.host link,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  typedef enum {ST_IDLE, ST_CLEAR, ST_INDEX, ST_DATA, ST_READ, ST_WAIT} host_state_e;

  host_state_e state_ff;
  logic [4:0] index_ff;
  logic [7:0] data_ff;
  logic read_op_ff;
  logic [7:0] result_ff;
  logic busy;
  logic cmd_ok;

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  // A command write waits while the previous sequence is still running.
  assign busy = (state_ff != ST_IDLE);
  assign cmd_ok = !(i_avs_write && i_avs_address == AVS_OFF_CMD && busy);

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest && cmd_ok);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= (i_avs_address == AVS_OFF_STATUS)
                          ? {23'h0, busy, result_ff} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      index_ff <= 5'h00;
      data_ff <= 8'h00;
      read_op_ff <= 1'b0;
      result_ff <= 8'h00;
      link.io_addr <= 16'h0000;
      link.io_wr <= 1'b0;
      link.io_rd <= 1'b0;
      link.io_wdata <= 8'h00;
    end else if (i_ce) begin
      link.io_wr <= 1'b0;
      link.io_rd <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (i_avs_write && !o_avs_waitrequest && i_avs_address == AVS_OFF_CMD) begin
            index_ff <= i_avs_writedata[CMD_INDEX_LSB +: 5];
            data_ff <= i_avs_writedata[7:0];
            read_op_ff <= i_avs_writedata[CMD_READ_BIT];
            link.io_addr <= PORT_STAT_COLOR;
            link.io_rd <= 1'b1;
            state_ff <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          link.io_addr <= PORT_ATTR_WR;
          link.io_wr <= 1'b1;
          // Keep the palette source on so the display path stays live.
          link.io_wdata <= {2'b00, 1'b1, index_ff};
          state_ff <= ST_INDEX;
        end
        ST_INDEX: begin
          if (read_op_ff) begin
            link.io_addr <= PORT_ATTR_RD;
            link.io_rd <= 1'b1;
            state_ff <= ST_READ;
          end else begin
            link.io_addr <= PORT_ATTR_WR;
            link.io_wr <= 1'b1;
            link.io_wdata <= data_ff;
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          state_ff <= ST_IDLE;
        end
        ST_READ: begin
          state_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (link.io_rvalid) begin
            result_ff <= link.io_rdata;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule // attr_host

// [verification/attr_link_checker.sv]
// Purpose: Watches the indexed I/O link between the host end and the device end.
// Assumes: Clock enable held high; the host uses only the colour status port.
// Notes: Shadow copies of the four registers predict every data read.
`timescale 1ns/1ps
module attr_link_checker
  import attr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  logic latch_ff;
  logic [4:0] idx_ff;
  logic [7:0] exp_ff;
  logic [7:0] shadow_ff [4];
  logic [4:0] sel;
  logic rd_stat, wr_attr, rd_data, mapped;
  assign sel = idx_ff - IDX_BORDER_COLOR;
  assign mapped = idx_ff >= IDX_BORDER_COLOR && idx_ff <= IDX_COLOR_PAGE;
  assign rd_stat = io_rd && (io_addr == PORT_STAT_COLOR || io_addr == PORT_STAT_MONO);
  assign wr_attr = io_wr && io_addr == PORT_ATTR_WR;
  assign rd_data = io_rd && io_addr == PORT_ATTR_RD;
  // A status read wins over a write in the same cycle, as in the device.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst || rd_stat) latch_ff <= 1'b0;
    else if (wr_attr) latch_ff <= !latch_ff;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) idx_ff <= 5'h00;
    else if (wr_attr && !latch_ff && !rd_stat) idx_ff <= io_wdata[4:0];
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) shadow_ff <= '{default: RST_REG};
    else if (wr_attr && latch_ff && !rd_stat && mapped) shadow_ff[sel[1:0]] <= io_wdata;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) exp_ff <= 8'h00;
    else if (rd_data) exp_ff <= mapped ? shadow_ff[sel[1:0]] : 8'h00;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_rvalid_after_rd: assert property (io_rd |=> io_rvalid)
    else $error("read not answered on the next cycle");
  a_rvalid_cause: assert property (io_rvalid |-> $past(io_rd))
    else $error("read valid without a read");
  a_rvalid_single: assert property (io_rvalid |=> !io_rvalid)
    else $error("read valid longer than one cycle");
  a_read_back: assert property (rd_data |=> io_rdata == exp_ff)
    else $error("register read back differs from last write");
  a_latch_clear: assert property (rd_stat |=> wr_attr && !latch_ff)
    else $error("status read not followed by address write");
  a_addr_after_stat: assert property (wr_attr && !latch_ff |-> $past(rd_stat))
    else $error("address write without latch clear before it");
  a_addr_byte: assert property (wr_attr && !latch_ff |-> io_wdata[7:5] == 3'h1)
    else $error("address byte lacks palette source bit");
  a_data_next: assert property (wr_attr && !latch_ff |=> wr_attr || rd_data)
    else $error("data access does not follow address write");
  a_data_rd_phase: assert property (rd_data |-> latch_ff)
    else $error("data read outside data phase");
endmodule // attr_link_checker

// [verification/tb_top.sv]
// Purpose: Drives the host end over Avalon-MM and checks registers and pixel path.
// Assumes: Host and device joined by one link; clock enable held high.
// Notes: Pixel checks wait well past the ten-clock pipeline before sampling.
`timescale 1ns/1ps
module tb_top
  import attr_pkg::*;
;
  localparam logic [7:0] VALS [4] = '{8'hA5, 8'h35, 8'h08, 8'h0D};
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, w;
  logic avs_waitrequest;
  logic [7:0] mode_ctl = 8'h00;
  logic mode_9dot = 1'h0, mode_256 = 1'h0, mode_narrow = 1'h0;
  logic active = 1'h0, border_band = 1'h0, line_compare = 1'h0, vsync = 1'h0;
  logic [5:0] palette = 6'h00;
  logic [7:0] attr256 = 8'h00, q, dac_color;
  logic [3:0] plane_data = 4'h0, plane_enabled, pan_pixels;
  logic [1:0] status_mux;
  logic [4:0] attr_index;
  logic palette_src;
  int err_count = 0;
  int total_checks = 0;
  attr_link_if link();
  always #25 clk_sys = !clk_sys;
  attr_host i_attr_host (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(1'h1), .link(link),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest));
  attr_device i_attr_device (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(1'h1), .link(link),
    .i_mode_ctl(mode_ctl), .i_mode_9dot(mode_9dot), .i_mode_256(mode_256),
    .i_mode_narrow(mode_narrow), .i_active(active), .i_border_band(border_band),
    .i_line_compare(line_compare), .i_vsync(vsync), .i_palette(palette),
    .i_attr256(attr256), .i_plane_data(plane_data), .o_plane_enabled(plane_enabled),
    .o_dac_color(dac_color), .o_status_mux(status_mux), .o_pan_pixels(pan_pixels),
    .o_attr_index(attr_index), .o_palette_src(palette_src));
  attr_link_checker i_attr_link_checker (.i_clk_sys(clk_sys), .i_nrst(nrst),
    .io_addr(link.io_addr), .io_wr(link.io_wr), .io_rd(link.io_rd), .io_wdata(link.io_wdata),
    .io_rdata(link.io_rdata), .io_rvalid(link.io_rvalid));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waitrequest is sampled at each rising edge; read data are taken at the accepting edge.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 100);
    r = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    chk(n < 100, 1);
  endtask
  task automatic cmd(input logic rd, input logic [4:0] idx, input logic [7:0] d,
                     output logic [7:0] r);
    logic [31:0] s;
    int n;
    n = 0;
    av(1'h1, AVS_OFF_CMD, {15'h0, rd, 3'h0, idx, d}, s);
    do begin
      av(1'h0, AVS_OFF_STATUS, 32'h0, s);
      n++;
    end while (s[STAT_BUSY_BIT] !== 1'h0 && n < 50);
    chk(32'(s[STAT_BUSY_BIT]), 32'h0);
    r = s[7:0];
  endtask
  task automatic settle;
    repeat (14) @(negedge clk_sys);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [3:0] pan_exp(input int m, input logic [3:0] v);
    if (m == 0) return (v < 4'h8) ? v + 4'h1 : 4'h0;
    if (m == 1) return (v < 4'h7) ? {1'h0, v[3:1]} : 4'h0;
    return (v < 4'h8) ? v : 4'h0;
  endfunction
  function automatic logic [1:0] mux_exp(input logic [1:0] s, input logic [7:0] c);
    case (s)
      2'h0: return {c[2], c[0]};
      2'h1: return {c[5], c[4]};
      2'h2: return {c[3], c[1]};
      default: return {c[7], c[6]};
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      cmd(1'h1, IDX_BORDER_COLOR + 5'(i), 8'h00, q);
      chk(q, 8'h00);
      cmd(1'h0, IDX_BORDER_COLOR + 5'(i), VALS[i], q);
      cmd(1'h1, IDX_BORDER_COLOR + 5'(i), 8'h00, q);
      chk(q, VALS[i]);
    end
    chk({palette_src, attr_index}, {1'h1, IDX_COLOR_PAGE});
    av(1'h0, 4'h8, 32'h0, w);
    chk(w, 32'h0);
    @(posedge clk_sys);
    plane_data <= 4'hB;
    active <= 1'h1;
    palette <= 6'h2A;
    settle;
    chk(plane_enabled, 4'h1);
    cmd(1'h0, IDX_FINE_SHIFT, 8'h00, q);
    for (int s = 0; s < 4; s++) begin
      cmd(1'h0, IDX_PLANE_ENABLE, {2'h0, 2'(s), 4'hF}, q);
      settle;
      chk(dac_color, 8'hEA);
      chk(status_mux, mux_exp(2'(s), 8'hEA));
    end
    @(posedge clk_sys);
    mode_ctl <= 8'h80;
    settle;
    chk(dac_color, 8'hDA);
    @(posedge clk_sys);
    mode_256 <= 1'h1;
    attr256 <= 8'h5C;
    settle;
    chk(dac_color, 8'h5C);
    @(posedge clk_sys);
    active <= 1'h0;
    border_band <= 1'h1;
    mode_narrow <= 1'h1;
    settle;
    chk(dac_color, 8'hA5);
    @(posedge clk_sys);
    mode_256 <= 1'h0;
    settle;
    chk(dac_color, 8'h00);
    @(posedge clk_sys);
    mode_narrow <= 1'h0;
    settle;
    chk(dac_color, 8'hA5);
    for (int m = 0; m < 3; m++) begin
      for (int v = 0; v < 9; v++) begin
        @(posedge clk_sys);
        mode_9dot <= (m == 0);
        mode_256 <= (m == 1);
        cmd(1'h0, IDX_FINE_SHIFT, 8'(v), q);
        repeat (3) @(negedge clk_sys);
        chk(pan_pixels, pan_exp(m, 4'(v)));
      end
    end
    @(posedge clk_sys);
    mode_ctl <= 8'h20;
    mode_256 <= 1'h0;
    cmd(1'h0, IDX_FINE_SHIFT, 8'h03, q);
    line_compare <= 1'h1;
    @(posedge clk_sys);
    line_compare <= 1'h0;
    settle;
    chk(pan_pixels, 4'h0);
    @(posedge clk_sys);
    vsync <= 1'h1;
    @(posedge clk_sys);
    vsync <= 1'h0;
    settle;
    chk(pan_pixels, 4'h3);
    print_verdict;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    print_verdict;
  end
endmodule // tb_top
